// File: rtl/cofp_pkg.sv
// constants for the cyclic output frame parser
package cofp_pkg;
	// frame variants
	localparam logic VAR_120 = 1'b0;
	localparam logic VAR_121 = 1'b1;
	// frame lengths in bytes
	localparam logic [8:0] MAX_LEN_120 = 9'd263;
	localparam logic [8:0] MAX_LEN_121 = 9'd262;
	// byte positions, first variant
	localparam logic [8:0] B120_SWOUT   = 9'd1;
	localparam logic [8:0] B120_FRAGNUM = 9'd2;
	localparam logic [8:0] B120_FRAGREM = 9'd3;
	localparam logic [8:0] B120_FRAGSZ  = 9'd4;
	localparam logic [8:0] B120_FLAGS   = 9'd5;
	localparam logic [8:0] B120_LEN_LO  = 9'd6;
	localparam logic [8:0] B120_LEN_HI  = 9'd7;
	localparam logic [8:0] B120_PAYLOAD = 9'd8;
	// byte positions, second variant
	localparam logic [8:0] B121_FRAGNUM = 9'd1;
	localparam logic [8:0] B121_FRAGREM = 9'd2;
	localparam logic [8:0] B121_FRAGSZ  = 9'd3;
	localparam logic [8:0] B121_FLAGS   = 9'd4;
	localparam logic [8:0] B121_LEN_LO  = 9'd5;
	localparam logic [8:0] B121_LEN_HI  = 9'd6;
	localparam logic [8:0] B121_PAYLOAD = 9'd7;
	localparam logic [8:0] B_CTRL       = 9'd0;
	// control byte fields
	localparam int CB_ACT     = 0;
	localparam int CB_DACK    = 1;
	localparam int CB_DRESET  = 2;
	localparam int CB_ERRACK  = 3;
	localparam int CB_STANDBY = 4;
	// flag byte fields
	localparam int FB_NEWDATA  = 0;
	localparam int FB_NEWENTRY = 1;
	// input frame result offset
	localparam logic [8:0] IN_RESULT_OFS = 9'd11;
	// register word offsets (byte addresses)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FRAG   = 8'h08;
	localparam logic [7:0] REG_ENTRY  = 8'h0c;
	localparam logic [7:0] REG_RESULT = 8'h10;
	localparam logic [7:0] REG_ENTCNT = 8'h14;
	// register fields
	localparam int CTRL_VAR    = 0;
	localparam int CTRL_EXT_LO = 4;
	localparam int STAT_OVR    = 16;
	// reset values
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic [7:0]  RESULT_RESET = 8'h00;
endpackage

// File: rtl/cofp_buf2.sv
// two-entry buffer with registered valid and ready
`timescale 1ns/100ps
module cofp_buf2 #(
	parameter int WIDTH = 9
) (
	input  wire logic             CLK,
	input  wire logic             RST,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] head_q;
	logic [WIDTH-1:0] tail_q;
	logic             head_v_q;
	logic             tail_v_q;
	logic             in_rdy_q;
	logic             push;
	logic             pop;

	assign push      = in_valid && !tail_v_q;
	assign pop       = head_v_q && out_ready;
	// ready has its own flop, always the inverse of tail_v_q
	assign in_ready  = in_rdy_q;
	assign out_valid = head_v_q;
	assign out_data  = head_q;

	always_ff @(posedge CLK) begin
		if (RST) begin
			head_v_q <= 1'b0;
			tail_v_q <= 1'b0;
			in_rdy_q <= 1'b1;
			head_q   <= '0;
			tail_q   <= '0;
		end else if (pop) begin
			if (tail_v_q) begin
				head_q   <= tail_q;
				tail_v_q <= 1'b0;
				in_rdy_q <= 1'b1;
			end else if (push) begin
				head_q <= in_data;
			end else begin
				head_v_q <= 1'b0;
			end
		end else if (push) begin
			if (!head_v_q) begin
				head_q   <= in_data;
				head_v_q <= 1'b1;
			end else begin
				tail_q   <= in_data;
				tail_v_q <= 1'b1;
				in_rdy_q <= 1'b0;
			end
		end
	end

	// a stalled word must hold still
	hold_head_a: assert property (@(posedge CLK) disable iff (RST)
		head_v_q && !out_ready |=> head_v_q && $stable(head_q))
		else $error("buffer head changed while stalled");
endmodule

// File: rtl/cofp_swout.sv
// switching output drive and event counter reset pulses
`timescale 1ns/100ps
module cofp_swout #(
	parameter int NOUT = 4
) (
	input  wire logic            CLK,
	input  wire logic            RST,
	input  wire logic            strobe,
	input  wire logic [7:0]      data,
	input  wire logic [NOUT-1:0] ext_en,
	output logic      [NOUT-1:0] drive,
	output logic      [NOUT-1:0] cnt_rst
);
	logic [NOUT-1:0] act_q;

	genvar g;
	generate
		for (g = 0; g < NOUT; g++) begin : g_out
			// even bit activates, odd bit resets the counter
			always_ff @(posedge CLK) begin
				if (RST) begin
					act_q[g]   <= 1'b0;
					drive[g]   <= 1'b0;
					cnt_rst[g] <= 1'b0;
				end else begin
					cnt_rst[g] <= strobe && data[2*g+1]; // [R03]
					if (strobe) begin
						act_q[g] <= data[2*g]; // [R03]
					end
					// masked, not lost: the bit returns once re-enabled
					drive[g] <= ext_en[g]
						&& (strobe ? data[2*g] : act_q[g]); // [R04]
				end
			end
		end
	endgenerate

	// not external event means the output stays low
	drive_gate_a: assert property (@(posedge CLK) disable iff (RST)
		!ext_en[0] |=> !drive[0]) // [R04]
		else $error("switching output driven without external event");
endmodule

// File: rtl/cofp_parser.sv
// cyclic output frame parser with Avalon-MM register slave
`timescale 1ns/100ps
// Summary of operation
// [R01] controller sends variant 120 frames of 1 to 263 bytes
// [R02] byte 0: activation, data ack, data reset, error ack, standby
// [R03] variant 120 byte 1: per output, even bit activates, odd resets counter
// [R04] switching output follows its bit only when set as external event
// [R05] variant 120 bytes 2-4 fragment fields, byte 5 bit 0 new data
// [R06] variant 120 entry length: byte 6 low, byte 7 high
// [R07] variant 120 payload from byte 8 to byte 262
// [R08] one-byte frame carries control only; two bytes add output bits
// [R09] variant 121: 1 to 262 bytes, fragment fields in bytes 1-3
// [R10] variant 121: flags byte 4, length bytes 5-6, payload from 7
// [R11] input frame result data start at byte 11
// [R12] each level change of new-entry toggle is one fresh entry
module cofp_parser (
	input  wire logic        CLK,
	input  wire logic        RST,
	// Avalon-MM slave
	input  wire logic [7:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// incoming frame bytes
	input  wire logic        FRM_VALID,
	output logic             FRM_READY,
	input  wire logic [7:0]  FRM_DATA,
	input  wire logic        FRM_LAST,
	// entry payload
	output logic             PAY_VALID,
	input  wire logic        PAY_READY,
	output logic      [7:0]  PAY_DATA,
	output logic             PAY_LAST,
	// decoded control bits
	output logic             CTL_ACTIVATE,
	output logic             CTL_DATA_ACK,
	output logic             CTL_DATA_RESET,
	output logic             CTL_ERROR_ACK,
	output logic             CTL_STANDBY,
	output logic             NEW_DATA,
	output logic             NEW_ENTRY,
	output logic      [3:0]  SW_OUT,
	output logic      [3:0]  SW_CNT_RST
);
	logic [31:0] ctrl_q;
	logic [7:0]  result_len_q;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        var_q;
	logic        var_now;
	logic [8:0]  idx_q;
	logic        acc;
	logic [8:0]  max_len;
	logic [8:0]  pay_ofs;
	logic        in_range;
	logic        is_payload;
	logic [7:0]  frag_num_q;
	logic [7:0]  frag_rem_q;
	logic [7:0]  frag_size_q;
	logic [15:0] entry_len_q;
	logic [8:0]  last_len_q;
	logic        toggle_q;
	logic [15:0] entry_cnt_q;
	logic        overrun_q;
	logic        ovr_set;
	logic        ovr_clr;
	logic        sw_strobe;
	logic        fresh_entry;
	logic        wr_go;
	logic [8:0]  buf_out;

	// frame byte handshake
	assign acc     = FRM_VALID && FRM_READY;
	assign var_now = (idx_q == cofp_pkg::B_CTRL) ? ctrl_q[cofp_pkg::CTRL_VAR]
		: var_q;
	assign max_len = (var_now == cofp_pkg::VAR_120) ? cofp_pkg::MAX_LEN_120
		: cofp_pkg::MAX_LEN_121; // [R01] [R09]
	assign pay_ofs = (var_now == cofp_pkg::VAR_120) ? cofp_pkg::B120_PAYLOAD
		: cofp_pkg::B121_PAYLOAD; // [R07] [R10]
	assign in_range   = idx_q < max_len;
	assign is_payload = in_range && (idx_q >= pay_ofs);

	// variant is latched at each frame's first byte
	always_ff @(posedge CLK) begin
		if (RST) begin
			var_q <= cofp_pkg::VAR_120;
		end else if (acc && idx_q == cofp_pkg::B_CTRL) begin
			var_q <= ctrl_q[cofp_pkg::CTRL_VAR];
		end
	end

	// byte position within the frame
	always_ff @(posedge CLK) begin
		if (RST) begin
			idx_q <= '0;
		end else if (acc) begin
			if (FRM_LAST) begin
				idx_q <= '0;
			end else if (idx_q != 9'h1ff) begin
				idx_q <= idx_q + 9'h001;
			end
		end
	end

	// frame length of the last complete frame
	always_ff @(posedge CLK) begin
		if (RST) begin
			last_len_q <= '0;
		end else if (acc && FRM_LAST) begin
			last_len_q <= idx_q + 9'h001;
		end
	end

	// control byte, both variants
	always_ff @(posedge CLK) begin
		if (RST) begin
			CTL_ACTIVATE   <= 1'b0;
			CTL_DATA_ACK   <= 1'b0;
			CTL_DATA_RESET <= 1'b0;
			CTL_ERROR_ACK  <= 1'b0;
			CTL_STANDBY    <= 1'b0;
		end else if (acc && idx_q == cofp_pkg::B_CTRL) begin
			CTL_ACTIVATE   <= FRM_DATA[cofp_pkg::CB_ACT]; // [R02]
			CTL_DATA_ACK   <= FRM_DATA[cofp_pkg::CB_DACK]; // [R02]
			CTL_DATA_RESET <= FRM_DATA[cofp_pkg::CB_DRESET]; // [R02]
			CTL_ERROR_ACK  <= FRM_DATA[cofp_pkg::CB_ERRACK]; // [R02]
			CTL_STANDBY    <= FRM_DATA[cofp_pkg::CB_STANDBY]; // [R02]
		end
	end

	// output byte exists only in the first variant, only if sent
	assign sw_strobe = acc && var_q == cofp_pkg::VAR_120
		&& idx_q == cofp_pkg::B120_SWOUT; // [R03] [R08]

	cofp_swout #(
		.NOUT(4)
	) u_swout (
		.CLK    (CLK),
		.RST    (RST),
		.strobe (sw_strobe),
		.data   (FRM_DATA),
		.ext_en (ctrl_q[cofp_pkg::CTRL_EXT_LO +: 4]),
		.drive  (SW_OUT),
		.cnt_rst(SW_CNT_RST)
	);

	// fragment fields and entry length; short frames leave them alone
	always_ff @(posedge CLK) begin
		if (RST) begin
			frag_num_q  <= '0;
			frag_rem_q  <= '0;
			frag_size_q <= '0;
			entry_len_q <= '0;
			NEW_DATA    <= 1'b0;
		end else if (acc && var_q == cofp_pkg::VAR_120) begin
			case (idx_q)
			cofp_pkg::B120_FRAGNUM: frag_num_q  <= FRM_DATA; // [R05]
			cofp_pkg::B120_FRAGREM: frag_rem_q  <= FRM_DATA; // [R05]
			cofp_pkg::B120_FRAGSZ:  frag_size_q <= FRM_DATA; // [R05]
			cofp_pkg::B120_FLAGS: begin
				NEW_DATA <= FRM_DATA[cofp_pkg::FB_NEWDATA]; // [R05]
			end
			cofp_pkg::B120_LEN_LO: entry_len_q[7:0]  <= FRM_DATA; // [R06]
			cofp_pkg::B120_LEN_HI: entry_len_q[15:8] <= FRM_DATA; // [R06]
			default: begin
			end
			endcase
		end else if (acc && var_q == cofp_pkg::VAR_121) begin
			case (idx_q)
			cofp_pkg::B121_FRAGNUM: frag_num_q  <= FRM_DATA; // [R09]
			cofp_pkg::B121_FRAGREM: frag_rem_q  <= FRM_DATA; // [R09]
			cofp_pkg::B121_FRAGSZ:  frag_size_q <= FRM_DATA; // [R09]
			cofp_pkg::B121_FLAGS: begin
				NEW_DATA <= FRM_DATA[cofp_pkg::FB_NEWDATA]; // [R10]
			end
			cofp_pkg::B121_LEN_LO: entry_len_q[7:0]  <= FRM_DATA; // [R10]
			cofp_pkg::B121_LEN_HI: entry_len_q[15:8] <= FRM_DATA; // [R10]
			default: begin
			end
			endcase
		end
	end

	// new-entry toggle: act once per level change
	assign fresh_entry = acc && var_q == cofp_pkg::VAR_121
		&& idx_q == cofp_pkg::B121_FLAGS
		&& FRM_DATA[cofp_pkg::FB_NEWENTRY] != toggle_q; // [R12]

	always_ff @(posedge CLK) begin
		if (RST) begin
			toggle_q    <= 1'b0;
			entry_cnt_q <= '0;
			NEW_ENTRY   <= 1'b0;
		end else begin
			NEW_ENTRY <= fresh_entry; // [R12]
			if (fresh_entry) begin
				toggle_q    <= FRM_DATA[cofp_pkg::FB_NEWENTRY]; // [R12]
				entry_cnt_q <= entry_cnt_q + 16'h0001;
			end
		end
	end

	// bytes past the longest frame are dropped and flagged
	assign ovr_set = acc && !in_range;
	assign ovr_clr = wr_go && AVS_ADDRESS == cofp_pkg::REG_STATUS
		&& AVS_BYTEENABLE[2] && AVS_WRITEDATA[cofp_pkg::STAT_OVR];

	always_ff @(posedge CLK) begin
		if (RST) begin
			overrun_q <= 1'b0;
		end else if (ovr_set) begin
			overrun_q <= 1'b1; // set wins over a clear in the same cycle
		end else if (ovr_clr) begin
			overrun_q <= 1'b0;
		end
	end

	// payload path; a stalled receiver stalls the frame source
	cofp_buf2 #(
		.WIDTH(9)
	) u_buf (
		.CLK      (CLK),
		.RST      (RST),
		.in_valid (FRM_VALID && is_payload), // [R07] [R10]
		.in_ready (FRM_READY),
		.in_data  ({FRM_LAST || idx_q == max_len - 9'h001, FRM_DATA}),
		.out_valid(PAY_VALID),
		.out_ready(PAY_READY),
		.out_data (buf_out)
	);
	assign PAY_DATA = buf_out[7:0];
	assign PAY_LAST = buf_out[8];

	// bus slave: one wait cycle, then the answer
	assign wr_go = AVS_WRITE && !wait_q;

	always_ff @(posedge CLK) begin
		if (RST) begin
			wait_q <= 1'b1;
		end else if ((AVS_READ || AVS_WRITE) && wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end
	assign AVS_WAITREQUEST = wait_q;

	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl_q       <= cofp_pkg::CTRL_RESET;
			result_len_q <= cofp_pkg::RESULT_RESET;
		end else if (wr_go) begin
			if (AVS_ADDRESS == cofp_pkg::REG_CTRL) begin
				if (AVS_BYTEENABLE[0]) begin
					ctrl_q[7:0] <= AVS_WRITEDATA[7:0];
				end
			end else if (AVS_ADDRESS == cofp_pkg::REG_RESULT) begin
				if (AVS_BYTEENABLE[0]) begin
					result_len_q <= AVS_WRITEDATA[7:0];
				end
			end
		end
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		case (AVS_ADDRESS)
		cofp_pkg::REG_CTRL: rdata_d = {24'h00_0000, ctrl_q[7:0]};
		cofp_pkg::REG_STATUS: rdata_d = {15'h0000, overrun_q, 6'h00,
			toggle_q, NEW_DATA, 3'h0, CTL_STANDBY, CTL_ERROR_ACK,
			CTL_DATA_RESET, CTL_DATA_ACK, CTL_ACTIVATE};
		cofp_pkg::REG_FRAG: rdata_d = {8'h00, frag_size_q, frag_rem_q,
			frag_num_q};
		cofp_pkg::REG_ENTRY: rdata_d = {7'h00, last_len_q, entry_len_q};
		// input frame length is the result offset plus the result length
		cofp_pkg::REG_RESULT: rdata_d = {7'h00,
			cofp_pkg::IN_RESULT_OFS + {1'b0, result_len_q}, 7'h00,
			cofp_pkg::IN_RESULT_OFS}; // [R11]
		cofp_pkg::REG_ENTCNT: rdata_d = {16'h0000, entry_cnt_q};
		default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			rdata_q <= '0;
		end else if (AVS_READ && wait_q) begin
			rdata_q <= rdata_d;
		end
	end
	assign AVS_READDATA = rdata_q;

	// control bits follow byte 0 at the next edge
	ctrl_decode_a: assert property (@(posedge CLK) disable iff (RST)
		acc && idx_q == cofp_pkg::B_CTRL |=>
		CTL_ACTIVATE == $past(FRM_DATA[0])
		&& CTL_STANDBY == $past(FRM_DATA[4])) // [R02]
		else $error("control byte decoded wrongly");

	// counter reset pulses follow the odd bits of byte 1
	swout_var_a: assert property (@(posedge CLK) disable iff (RST)
		sw_strobe |=> SW_CNT_RST == {$past(FRM_DATA[7]),
		$past(FRM_DATA[5]), $past(FRM_DATA[3]), $past(FRM_DATA[1])}) // [R03]
		else $error("output byte taken at wrong place");

	// first variant length byte 7 lands in the high half
	len_120_a: assert property (@(posedge CLK) disable iff (RST)
		acc && var_q == cofp_pkg::VAR_120 && idx_q == 9'd7 |=>
		entry_len_q[15:8] == $past(FRM_DATA)) // [R06]
		else $error("entry length high byte misplaced");

	// second variant flags byte sets the new data flag
	flags_121_a: assert property (@(posedge CLK) disable iff (RST)
		acc && var_q == cofp_pkg::VAR_121 && idx_q == 9'd4 |=>
		NEW_DATA == $past(FRM_DATA[0])) // [R10]
		else $error("new data flag misread");

	// fragment number at byte 2 in the first variant
	frag_120_a: assert property (@(posedge CLK) disable iff (RST)
		acc && var_q == cofp_pkg::VAR_120 && idx_q == 9'd2 |=>
		frag_num_q == $past(FRM_DATA)) // [R05]
		else $error("fragment number misread");

	// first variant header bytes never reach the payload
	pay_start_a: assert property (@(posedge CLK) disable iff (RST)
		FRM_VALID && var_now == cofp_pkg::VAR_120 && idx_q < 9'd8
		|-> !is_payload) // [R07]
		else $error("header byte sent as payload");

	// toggle change pulses once, equal level never
	entry_once_a: assert property (@(posedge CLK) disable iff (RST)
		NEW_ENTRY |-> toggle_q != $past(toggle_q) ##1 !NEW_ENTRY) // [R12]
		else $error("new entry pulse repeated");

	// second variant rejects byte 262 onward
	len_121_a: assert property (@(posedge CLK) disable iff (RST)
		acc && var_now == cofp_pkg::VAR_121 && idx_q >= 9'd262
		|=> overrun_q) // [R09]
		else $error("overlong frame not flagged");

	// a request is answered after exactly one wait cycle
	bus_answer_a: assert property (@(posedge CLK) disable iff (RST)
		(AVS_READ || AVS_WRITE) && wait_q |=> !wait_q ##1 wait_q)
		else $error("bus answer timing wrong");
endmodule

// File: testbench/cofp_ctrl_model.sv
// controller model that streams cyclic output frames byte by byte
`timescale 1ns/100ps
module cofp_ctrl_model (
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic       start,
	input  wire logic       slow,
	input  wire logic [8:0] len,
	input  wire logic       ready,
	output logic            valid,
	output logic      [7:0] data,
	output logic            last,
	output logic            busy
);
	logic [7:0] mem [0:262];
	logic [8:0] idx_q;

	initial data = 8'h5a;

	// frame length from 1 up to 263 is chosen by the bench
	always @(posedge CLK) begin
		if (RST) begin
			valid <= 1'b0;
			last  <= 1'b0;
			busy  <= 1'b0;
			idx_q <= 9'h000;
			data  <= ~data;
		end else if (valid && !ready) begin
			// byte offered stays put until taken
		end else if (valid && last) begin
			valid <= 1'b0;
			last  <= 1'b0;
			busy  <= 1'b0;
			idx_q <= 9'h000;
			data  <= ~data;
		end else if ((busy || start) && !(slow && valid)) begin
			valid <= 1'b1;
			busy  <= 1'b1;
			data  <= mem[idx_q];
			last  <= (idx_q == len - 9'h001);
			idx_q <= idx_q + 9'h001;
		end else begin
			// released bus inverts the byte at every idle edge, so it never holds the stale byte still
			valid <= 1'b0;
			last  <= 1'b0;
			data  <= ~data;
		end
	end
endmodule

// File: testbench/cofp_parser_tb.sv
// self-checking bench for the cyclic output frame parser
`timescale 1ns/100ps
module cofp_parser_tb;
	logic        CLK = 1'b0;
	logic        RST = 1'b1;
	logic [7:0]  adr = 8'h00;
	logic        rd = 1'b0;
	logic        wrq = 1'b0;
	logic [31:0] wd = 32'h0;
	logic        pay_rdy = 1'b0;
	logic        stall = 1'b0;
	logic        m_start = 1'b0;
	logic        m_slow = 1'b0;
	logic [8:0]  m_len = 9'h001;
	logic [31:0] seed = 32'h6098;
	wire  [31:0] rdat;
	wire         wreq, fv, frdy, fl, pv, pl, nd, nent, m_busy;
	wire  [7:0]  fd, pd;
	wire  [4:0]  ctl;
	wire  [3:0]  swo, swr;
	logic [8:0]  expq [$];
	logic [7:0]  hdr [0:7];
	logic [3:0]  e_sw = 4'h0;
	logic [4:0]  e_ctl = 5'h0;
	logic [23:0] e_frag = 24'h0;
	logic [15:0] e_len = 16'h0;
	logic [15:0] e_ent = 16'h0;
	logic        e_nd = 1'b0;
	logic        e_tog = 1'b0;
	int          pn = 0;
	int          ne = 0;
	int          n_tests = 0;
	int          n_mismatch = 0;

	always #2.5 CLK = ~CLK;

	cofp_parser dut (
		.CLK(CLK), .RST(RST), .AVS_ADDRESS(adr), .AVS_READ(rd),
		.AVS_WRITE(wrq), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf),
		.AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .FRM_VALID(fv),
		.FRM_READY(frdy), .FRM_DATA(fd), .FRM_LAST(fl), .PAY_VALID(pv),
		.PAY_READY(pay_rdy), .PAY_DATA(pd), .PAY_LAST(pl),
		.CTL_ACTIVATE(ctl[0]), .CTL_DATA_ACK(ctl[1]),
		.CTL_DATA_RESET(ctl[2]), .CTL_ERROR_ACK(ctl[3]),
		.CTL_STANDBY(ctl[4]), .NEW_DATA(nd), .NEW_ENTRY(nent),
		.SW_OUT(swo), .SW_CNT_RST(swr)
	);

	cofp_ctrl_model m (
		.CLK(CLK), .RST(RST), .start(m_start), .slow(m_slow),
		.len(m_len), .ready(frdy), .valid(fv), .data(fd), .last(fl),
		.busy(m_busy)
	);

	function automatic logic [7:0] rb();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	// one nibble per output, so a doubled pulse shows in the sum
	function automatic logic [31:0] wt(input logic [3:0] b);
		return {19'h0, b[3], 3'h0, b[2], 3'h0, b[1], 3'h0, b[0]};
	endfunction

	function automatic logic [31:0] pop();
		return expq.size() != 0 ? {23'h0, expq.pop_front()} : 32'hffff_ffff;
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h want=%h", $time, got, want);
		end
	endtask

	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int i;
		adr <= a;
		wd  <= d;
		wrq <= wr;
		rd  <= !wr;
		for (i = 0; i < 50; i++) begin
			@(posedge CLK);
			if (wreq === 1'b0) break;
		end
		q = rdat;
		wrq <= 1'b0;
		rd  <= 1'b0;
		if (i == 50) begin
			n_mismatch++;
			test_done();
		end
		// one idle edge so the next call never re-drives in this step
		@(posedge CLK);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] msk,
			input logic [31:0] want);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q & msk, want);
	endtask

	task automatic frame(input logic v, input int n, input logic slw);
		int i, p, lim;
		p = v ? 7 : 8;
		lim = (v && n > 262) ? 262 : n;
		for (i = 0; i < n; i++) begin
			m.mem[i] = (i < p) ? hdr[i] : rb();
			if (i >= p && i < lim)
				expq.push_back({i == lim - 1, m.mem[i]});
		end
		m_len   <= 9'(n);
		m_slow  <= slw;
		m_start <= 1'b1;
		@(posedge CLK);
		m_start <= 1'b0;
	endtask

	task automatic drain();
		int i;
		repeat (2) @(posedge CLK);
		for (i = 0; i < 3000; i++) begin
			@(negedge CLK);
			if (!m_busy && expq.size() == 0) break;
		end
		repeat (4) @(posedge CLK);
		if (i == 3000) begin
			n_mismatch++;
			test_done();
		end
	endtask

	// random sink stalls; payload checked in order as it leaves
	always @(posedge CLK) begin
		pay_rdy <= !stall && rb() > 8'h50;
		if (!RST) begin
			pn <= pn + int'(wt(swr));
			ne <= ne + int'(nent);
			if (pv === 1'b1 && pay_rdy)
				chk({23'h0, pl, pd}, pop());
		end
	end

	initial begin
		int         k, i, n, fb, nee, p0, ne0;
		logic       v;
		logic [7:0] r;
		logic [3:0] en;
		logic [31:0] e_pn;
		repeat (10) @(posedge CLK);
		RST <= 1'b0;
		@(negedge CLK);
		chk({14'h0, frdy, wreq, pv, ctl, nd, nent, swo, swr}, 32'h3_0000);
		@(posedge CLK);
		rchk(cofp_pkg::REG_CTRL, 32'hffff_ffff, cofp_pkg::CTRL_RESET);
		wr(cofp_pkg::REG_FRAG, 32'hffff_ffff);
		rchk(cofp_pkg::REG_FRAG, 32'hffff_ffff, 32'h0);
		rchk(8'h18, 32'hffff_ffff, 32'h0);
		rchk(cofp_pkg::REG_STATUS, 32'hffff_ffff, 32'h0);
		for (k = 0; k < 12; k++) begin
			v = k[0];
			r = rb();
			en = r[3:0];
			wr(cofp_pkg::REG_CTRL, {24'h0, en, 3'h0, v});
			for (i = 0; i < 8; i++) hdr[i] = rb();
			if (k == 7) hdr[4][1] = e_tog;
			if (k == 9) hdr[4][1] = ~e_tog;
			case (k)
				0, 1: n = 1;
				2: n = 2;
				4: n = 8;
				6: n = 40;
				8: n = 7;
				default: n = (v ? 7 : 8) + rb() % 24;
			endcase
			e_ctl = hdr[0][4:0];
			e_pn = 32'h0;
			if (!v && n > 1) begin
				e_sw = {hdr[1][6], hdr[1][4], hdr[1][2], hdr[1][0]};
				e_pn = wt({hdr[1][7], hdr[1][5], hdr[1][3], hdr[1][1]});
			end
			fb = v ? 1 : 2;
			nee = 0;
			if (n > fb + 3) begin
				e_frag = {hdr[fb + 2], hdr[fb + 1], hdr[fb]};
				e_nd = hdr[fb + 3][0];
				if (v && hdr[4][1] !== e_tog) begin
					nee = 1;
					e_tog = hdr[4][1];
					e_ent++;
				end
			end
			// short frames update only the length bytes they carry
			if (n > fb + 4) e_len[7:0] = hdr[fb + 4];
			if (n > fb + 5) e_len[15:8] = hdr[fb + 5];
			p0 = pn;
			ne0 = ne;
			stall <= (k == 6);
			r = rb();
			frame(v, n, r[0]);
			if (k == 6) begin
				repeat (40) @(negedge CLK);
				chk({30'h0, frdy, pv}, 32'h1);
				@(posedge CLK);
				stall <= 1'b0;
			end
			drain();
			chk({27'h0, ctl}, {27'h0, e_ctl});
			chk({28'h0, swo}, {28'h0, e_sw & en});
			chk(32'(pn - p0), e_pn);
			chk(32'(ne - ne0), 32'(nee));
			chk({31'h0, nd}, {31'h0, e_nd});
			rchk(cofp_pkg::REG_STATUS, 32'h31f, {22'h0, e_tog, e_nd, 3'h0, e_ctl});
			rchk(cofp_pkg::REG_FRAG, 32'hff_ffff, {8'h0, e_frag});
			rchk(cofp_pkg::REG_ENTRY, 32'h1ff_ffff, {7'h0, 9'(n), e_len});
			rchk(cofp_pkg::REG_ENTCNT, 32'hffff, {16'h0, e_ent});
		end
		wr(cofp_pkg::REG_CTRL, 32'h0);
		frame(1'b0, 263, 1'b0);
		drain();
		rchk(cofp_pkg::REG_STATUS, 32'h1_0000, 32'h0);
		wr(cofp_pkg::REG_CTRL, 32'h1);
		frame(1'b1, 263, 1'b0);
		drain();
		rchk(cofp_pkg::REG_STATUS, 32'h1_0000, 32'h1_0000);
		wr(cofp_pkg::REG_STATUS, 32'h1_0000);
		rchk(cofp_pkg::REG_STATUS, 32'h1_0000, 32'h0);
		for (k = 0; k < 3; k++) begin
			r = (k == 0) ? 8'hff : rb();
			wr(cofp_pkg::REG_RESULT, {24'h0, r});
			rchk(cofp_pkg::REG_RESULT, 32'h1ff_01ff, {7'h0, 9'h00b + 9'(r), 7'h0, 9'h00b});
		end
		test_done();
	end
endmodule
